// file: verilog/uartb_pkg.sv
/*
  Constants shared by the buffered serial channel: register map, field
  positions, reset values, codes and receiver states.
  Assumes a 32-bit register bus with one aligned word per register.
*/
package uartb_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] UARTB_ADDR_MODE = 8'h00;
  localparam logic [7:0] UARTB_ADDR_DIV = 8'h04;
  localparam logic [7:0] UARTB_ADDR_TXBUF = 8'h08;
  localparam logic [7:0] UARTB_ADDR_RXBUF = 8'h0c;
  localparam logic [7:0] UARTB_ADDR_ERRST = 8'h10;
  localparam logic [7:0] UARTB_ADDR_TXST = 8'h14;
  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int UARTB_MODE_POWER = 7;
  localparam int UARTB_MODE_TXEN = 6;
  localparam int UARTB_MODE_RXEN = 5;
  localparam int UARTB_MODE_STOP2 = 4;
  localparam int UARTB_MODE_CHAR8 = 3;
  localparam int UARTB_MODE_PAR_HI = 2;
  localparam int UARTB_MODE_PAR_LO = 1;
  localparam int UARTB_MODE_MERGE = 0;
  localparam logic [1:0] UARTB_PAR_NONE = 2'h0;
  localparam logic [1:0] UARTB_PAR_ZERO = 2'h1;
  localparam logic [1:0] UARTB_PAR_ODD = 2'h2;
  localparam logic [1:0] UARTB_PAR_EVEN = 2'h3;
  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int UARTB_ERR_OVR = 0;
  localparam int UARTB_ERR_PAR = 1;
  localparam int UARTB_ERR_FRM = 2;
  localparam int UARTB_ST_BUSY = 0;
  localparam int UARTB_ST_FULL = 1;
  // ----------------------------------------------------------------
  // Reset values, limits, bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] UARTB_MODE_RST = 8'h00;
  localparam logic [7:0] UARTB_DIV_RST = 8'hff;
  localparam logic [7:0] UARTB_RXBUF_RST = 8'hff;
  localparam logic [7:0] UARTB_DIV_MIN = 8'h08;
  localparam logic [1:0] UARTB_RESP_OKAY = 2'h0;
  localparam logic [1:0] UARTB_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {UARTB_RX_IDLE, UARTB_RX_START, UARTB_RX_DATA,
                            UARTB_RX_PAR, UARTB_RX_STOP} uartb_rx_st_t;
endpackage

// file: verilog/uartb_filter.sv
/*
  Receive noise filter: two samples on the base clock, output follows
  only when both agree.
  Assumes the pin input is synchronous to clock_in.
*/
`timescale 1ns/1ps
module uartb_filter
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic filt_out
);
  typedef struct packed {
    logic s0;
    logic s1;
    logic filt;
  } uartb_filt_st_t;
  uartb_filt_st_t s_r;
  uartb_filt_st_t s_nxt;
  // ----------------------------------------------------------------
  // Match detector
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s0 = pin_in;
    s_nxt.s1 = s_r.s0;
    if (s_r.s0 == s_r.s1)
    begin
      s_nxt.filt = s_r.s1;
    end
  end
  // State register, line idles high
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= '1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign filt_out = s_r.filt;
endmodule // uartb_filter

// file: verilog/uartb_baud.sv
/*
  Baud counter: one-cycle tick every divisor cycles, i.e. twice per bit.
  Assumes the divisor is already clamped to its legal range.
*/
`timescale 1ns/1ps
module uartb_baud
#(
  parameter int CNT_W = 8
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic [CNT_W-1:0] divisor_in,
  output logic tick_out
);
  if (CNT_W < 4)
  begin : g_chk
    $error("uartb_baud: counter too narrow");
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } uartb_baud_st_t;
  uartb_baud_st_t s_r;
  uartb_baud_st_t s_nxt;
  // ----------------------------------------------------------------
  // Half-bit counter
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run_in || clear_in)
    begin
      s_nxt.cnt = '0;
    end
    else if (s_r.cnt == divisor_in - CNT_W'(1))
    begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + CNT_W'(1);
    end
  end
  // State register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign tick_out = s_r.tick;
endmodule // uartb_baud

// file: verilog/uartb_top.sv
/*
  Buffered serial channel: double-buffered transmitter, receiver with
  start validation and error flags, AXI4-Lite register slave.
  Assumes one clock, AXI master keeps valid/payload stable until taken.
*/
`timescale 1ns/1ps
module uartb_top
  import uartb_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic tx_done_irq_out,
  output logic rx_done_irq_out,
  output logic rx_error_irq_out
);
  if (ADDR_W < 8)
  begin : g_chk
    $error("uartb_top: address too narrow");
  end
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mode;
    logic [7:0] divisor;
    logic [7:0] hold_buf;
    logic hold_full;
    logic busy;
    logic [11:0] tx_frame;
    logic [3:0] tx_left;
    logic tx_phase;
    logic tx_out;
    logic tx_done;
    logic tx_clr;
    uartb_rx_st_t rx_st;
    logic [7:0] rx_shift;
    logic [3:0] rx_cnt;
    logic rx_phase;
    logic rx_par;
    logic rx_perr;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [2:0] err;
    logic rx_done;
    logic rx_err;
    logic rx_clr;
    logic filt_q;
  } uartb_top_st_t;
  uartb_top_st_t s_r;
  uartb_top_st_t s_nxt;
  logic filt;
  logic tx_tick;
  logic rx_tick;
  logic [7:0] div_eff;
  logic tx_en;
  logic rx_en;
  logic [1:0] par_mode;
  // ----------------------------------------------------------------
  // Frame builder: start, data LSB first, parity, stop bits
  // ----------------------------------------------------------------
  function automatic logic [15:0] uartb_build(input logic [7:0] data, input logic [7:0] mode);
    logic [11:0] f;
    logic [3:0] nd;
    logic [3:0] len;
    logic p;
    f = 12'hfff;
    nd = mode[UARTB_MODE_CHAR8] ? 4'h8 : 4'h7;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < nd)
      begin
        f[i + 1] = data[i];
      end
    end
    p = ^(mode[UARTB_MODE_CHAR8] ? data : {1'b0, data[6:0]});
    len = 4'h2 + nd;
    case (mode[UARTB_MODE_PAR_HI:UARTB_MODE_PAR_LO])
      UARTB_PAR_ODD: f[nd + 4'h1] = ~p;
      UARTB_PAR_EVEN: f[nd + 4'h1] = p;
      UARTB_PAR_ZERO: f[nd + 4'h1] = 1'b0;
      default: f[nd + 4'h1] = 1'b1;
    endcase
    if (mode[UARTB_MODE_PAR_HI:UARTB_MODE_PAR_LO] != UARTB_PAR_NONE)
    begin
      len = len + 4'h1;
    end
    if (mode[UARTB_MODE_STOP2])
    begin
      len = len + 4'h1;
    end
    return {len, f};
  endfunction
  // ----------------------------------------------------------------
  // Submodules: filter and the two baud counters
  // ----------------------------------------------------------------
  assign div_eff = (s_r.divisor < UARTB_DIV_MIN) ? UARTB_DIV_MIN : s_r.divisor;
  assign tx_en = s_r.mode[UARTB_MODE_POWER] & s_r.mode[UARTB_MODE_TXEN];
  assign rx_en = s_r.mode[UARTB_MODE_POWER] & s_r.mode[UARTB_MODE_RXEN];
  assign par_mode = s_r.mode[UARTB_MODE_PAR_HI:UARTB_MODE_PAR_LO];
  uartb_filter u_filter (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in(serial_in_pin_in),
    .filt_out(filt)
  );
  uartb_baud #(.CNT_W(8)) u_tx_baud (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .run_in(tx_en),
    .clear_in(s_r.tx_clr),
    .divisor_in(div_eff),
    .tick_out(tx_tick)
  );
  uartb_baud #(.CNT_W(8)) u_rx_baud (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .run_in(rx_en && s_r.rx_st != UARTB_RX_IDLE),
    .clear_in(s_r.rx_clr),
    .divisor_in(div_eff),
    .tick_out(rx_tick)
  );
  // ----------------------------------------------------------------
  // Next-state logic: bus slave, transmitter, receiver
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [15:0] fb;
    logic rd_err;
    logic rd_buf;
    logic [2:0] new_err;
    logic done;
    logic wr_hold;
    fb = '0;
    rd_err = 1'b0;
    rd_buf = 1'b0;
    new_err = 3'h0;
    done = 1'b0;
    wr_hold = 1'b0;
    s_nxt = s_r;
    s_nxt.tx_done = 1'b0;
    s_nxt.tx_clr = 1'b0;
    s_nxt.rx_done = 1'b0;
    s_nxt.rx_err = 1'b0;
    s_nxt.rx_clr = 1'b0;
    s_nxt.filt_q = filt;
    // Write channels, taken in either order
    if (s_r.bvalid && axi_bready_in)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (axi_awvalid_in && s_r.awready)
    begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = axi_awaddr_in[7:0];
    end
    if (axi_wvalid_in && s_r.wready)
    begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = axi_wdata_in[7:0];
      s_nxt.w_lane0 = axi_wstrb_in[0];
    end
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid)
    begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = UARTB_RESP_OKAY;
      case (s_r.aw_addr)
        UARTB_ADDR_MODE: if (s_r.w_lane0) s_nxt.mode = s_r.w_data;
        UARTB_ADDR_DIV: if (s_r.w_lane0) s_nxt.divisor = s_r.w_data;
        UARTB_ADDR_TXBUF:
          if (s_r.w_lane0 && tx_en)
          begin
            s_nxt.hold_buf = s_r.w_data;
            s_nxt.hold_full = 1'b1;
            wr_hold = 1'b1;
          end
        UARTB_ADDR_RXBUF, UARTB_ADDR_ERRST, UARTB_ADDR_TXST: s_nxt.bresp = UARTB_RESP_OKAY;
        default: s_nxt.bresp = UARTB_RESP_SLVERR;
      endcase
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
    // Read channel, with read side effects
    if (s_r.rvalid && axi_rready_in)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (axi_arvalid_in && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = UARTB_RESP_OKAY;
      s_nxt.rdata = 32'h0;
      case (axi_araddr_in[7:0])
        UARTB_ADDR_MODE: s_nxt.rdata[7:0] = s_r.mode;
        UARTB_ADDR_DIV: s_nxt.rdata[7:0] = s_r.divisor;
        UARTB_ADDR_TXBUF: s_nxt.rdata[7:0] = s_r.hold_buf;
        UARTB_ADDR_RXBUF:
        begin
          s_nxt.rdata[7:0] = s_r.rx_buf;
          rd_buf = 1'b1;
        end
        UARTB_ADDR_ERRST:
        begin
          s_nxt.rdata[2:0] = s_r.err;
          rd_err = 1'b1;
        end
        UARTB_ADDR_TXST:
        begin
          s_nxt.rdata[UARTB_ST_FULL] = s_r.hold_full;
          s_nxt.rdata[UARTB_ST_BUSY] = s_r.busy;
        end
        default: s_nxt.rresp = UARTB_RESP_SLVERR;
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;
    // Transmitter: shift out, then reload from the holding buffer
    if (!tx_en)
    begin
      s_nxt.hold_full = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.tx_left = 4'h0;
      s_nxt.tx_phase = 1'b0;
    end
    else
    begin
      // Stale tick from before the counter restart would halve the start bit
      if (s_r.busy && tx_tick && !s_r.tx_clr)
      begin
        s_nxt.tx_phase = !s_r.tx_phase;
        if (s_r.tx_phase)
        begin
          s_nxt.tx_frame = {1'b1, s_r.tx_frame[11:1]};
          s_nxt.tx_left = s_r.tx_left - 4'h1;
          if (s_r.tx_left == 4'h1)
          begin
            s_nxt.busy = 1'b0;
            s_nxt.tx_done = 1'b1;
          end
        end
      end
      if (!s_nxt.busy && s_r.hold_full)
      begin
        fb = uartb_build(s_r.hold_buf, s_r.mode);
        s_nxt.tx_frame = fb[11:0];
        s_nxt.tx_left = fb[15:12];
        s_nxt.busy = 1'b1;
        s_nxt.hold_full = wr_hold; // Write in the load cycle stays pending
        s_nxt.tx_phase = 1'b0;
        s_nxt.tx_clr = 1'b1;
      end
    end
    s_nxt.tx_out = s_nxt.busy ? s_nxt.tx_frame[0] : 1'b1;
    // Receiver state machine
    case (s_r.rx_st)
      UARTB_RX_IDLE:
        if (rx_en && s_r.filt_q && !filt)
        begin
          s_nxt.rx_st = UARTB_RX_START;
          s_nxt.rx_clr = 1'b1;
        end
      UARTB_RX_START:
        if (rx_tick)
        begin
          s_nxt.rx_st = filt ? UARTB_RX_IDLE : UARTB_RX_DATA;
          s_nxt.rx_cnt = 4'h0;
          s_nxt.rx_phase = 1'b0;
          s_nxt.rx_par = 1'b0;
          s_nxt.rx_perr = 1'b0;
          s_nxt.rx_shift = 8'h00;
        end
      UARTB_RX_DATA:
        if (rx_tick)
        begin
          s_nxt.rx_phase = !s_r.rx_phase;
          if (s_r.rx_phase)
          begin
            s_nxt.rx_shift[s_r.rx_cnt[2:0]] = filt;
            s_nxt.rx_par = s_r.rx_par ^ filt;
            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
            if (s_r.rx_cnt == (s_r.mode[UARTB_MODE_CHAR8] ? 4'h7 : 4'h6))
            begin
              s_nxt.rx_st = (par_mode == UARTB_PAR_NONE) ? UARTB_RX_STOP : UARTB_RX_PAR;
            end
          end
        end
      UARTB_RX_PAR:
        if (rx_tick)
        begin
          s_nxt.rx_phase = !s_r.rx_phase;
          if (s_r.rx_phase)
          begin
            s_nxt.rx_st = UARTB_RX_STOP;
            s_nxt.rx_perr = (par_mode == UARTB_PAR_ODD && !(s_r.rx_par ^ filt)) ||
                            (par_mode == UARTB_PAR_EVEN && (s_r.rx_par ^ filt));
          end
        end
      UARTB_RX_STOP:
        if (rx_tick)
        begin
          s_nxt.rx_phase = !s_r.rx_phase;
          if (s_r.rx_phase)
          begin
            s_nxt.rx_st = UARTB_RX_IDLE;
            done = 1'b1;
            new_err[UARTB_ERR_FRM] = !filt;
            new_err[UARTB_ERR_PAR] = s_r.rx_perr;
            new_err[UARTB_ERR_OVR] = s_r.rx_full && !rd_buf;
          end
        end
      default: s_nxt.rx_st = UARTB_RX_IDLE;
    endcase
    if (!rx_en)
    begin
      s_nxt.rx_st = UARTB_RX_IDLE;
    end
    // Buffer, flags and interrupt routing; a new event beats a read
    if (rd_buf)
    begin
      s_nxt.rx_full = 1'b0;
    end
    if (done && !new_err[UARTB_ERR_OVR])
    begin
      s_nxt.rx_buf = s_r.rx_shift;
      s_nxt.rx_full = 1'b1;
    end
    s_nxt.err = (rd_err ? 3'h0 : s_r.err) | new_err;
    if (done)
    begin
      s_nxt.rx_done = (new_err == 3'h0) || s_r.mode[UARTB_MODE_MERGE];
      s_nxt.rx_err = (new_err != 3'h0) && !s_r.mode[UARTB_MODE_MERGE];
    end
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
      s_r.mode <= UARTB_MODE_RST;
      s_r.divisor <= UARTB_DIV_RST;
      s_r.rx_buf <= UARTB_RXBUF_RST;
      s_r.tx_out <= 1'b1;
      s_r.filt_q <= 1'b1;
      s_r.rx_st <= UARTB_RX_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  // Outputs straight from the state register
  assign axi_awready_out = s_r.awready;
  assign axi_wready_out = s_r.wready;
  assign axi_bvalid_out = s_r.bvalid;
  assign axi_bresp_out = s_r.bresp;
  assign axi_arready_out = s_r.arready;
  assign axi_rvalid_out = s_r.rvalid;
  assign axi_rdata_out = s_r.rdata;
  assign axi_rresp_out = s_r.rresp;
  assign serial_out_pin_out = s_r.tx_out;
  assign tx_done_irq_out = s_r.tx_done;
  assign rx_done_irq_out = s_r.rx_done;
  assign rx_error_irq_out = s_r.rx_err;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_TX_ACCEPT: assert property (@(posedge clock_in) disable iff (rst_in)
    (tx_en && s_r.busy && s_r.hold_full && tx_tick && s_r.tx_phase && s_r.tx_left == 4'h1)
    |=> (s_r.busy && !s_r.hold_full && s_r.tx_done))
    else $error("holding byte not moved at frame end");
  AST_AUTO_LOAD: assert property (@(posedge clock_in) disable iff (rst_in)
    (tx_en && !s_r.busy && s_r.hold_full && s_r.mode == $past(s_r.mode))
    |=> (s_r.busy && s_r.tx_clr && !s_r.tx_frame[0]))
    else $error("idle shifter did not load");
  AST_STATUS_RD: assert property (@(posedge clock_in) disable iff (rst_in)
    (axi_arvalid_in && s_r.arready && axi_araddr_in[7:0] == UARTB_ADDR_TXST)
    |=> (s_r.rdata[1:0] == {$past(s_r.hold_full), $past(s_r.busy)} && s_r.rvalid))
    else $error("transmit status read wrong");
  AST_IDLE_HIGH: assert property (@(posedge clock_in) disable iff (rst_in)
    (!s_r.busy) |-> serial_out_pin_out)
    else $error("line not high while idle");
  AST_RX_GATE: assert property (@(posedge clock_in) disable iff (rst_in)
    (!rx_en) |=> (s_r.rx_st == UARTB_RX_IDLE))
    else $error("receiver ran while disabled");
  AST_START_CHECK: assert property (@(posedge clock_in) disable iff (rst_in)
    (rx_en && s_r.rx_st == UARTB_RX_START && rx_tick && filt) |=> (s_r.rx_st == UARTB_RX_IDLE))
    else $error("false start accepted");
  AST_OVR_KEEP: assert property (@(posedge clock_in) disable iff (rst_in)
    (s_r.err[UARTB_ERR_OVR] && !$past(s_r.err[UARTB_ERR_OVR]))
    |-> (s_r.rx_buf == $past(s_r.rx_buf)))
    else $error("buffer overwritten on overrun");
  AST_ERR_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
    (axi_arvalid_in && s_r.arready && axi_araddr_in[7:0] == UARTB_ADDR_ERRST
     && s_r.rx_st != UARTB_RX_STOP) |=> (s_r.err == 3'h0 && s_r.rdata[2:0] == $past(s_r.err)))
    else $error("error flags not cleared by read");
  AST_MERGE: assert property (@(posedge clock_in) disable iff (rst_in)
    rx_error_irq_out |-> (!$past(s_r.mode[UARTB_MODE_MERGE]) && !rx_done_irq_out && s_r.err != 3'h0))
    else $error("error interrupt routed wrongly");
endmodule // uartb_top

// file: tb/uartb_node.sv
/*
  Remote serial node: sends frames on the receive pin, decodes the
  transmit pin. Assumes 8 data bits, even parity, LSB first.
*/
`timescale 1ns/1ps
module uartb_node
#(
  parameter int BIT_CLKS = 16
)
(
  input wire logic clock_in,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got_q[$];
  int bad_cnt = 0;
  initial line_out = 1'b1;
  // ------------------------------------------------------------
  // Sender: bad flags spoil parity or stop
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clock_in);
    end
    line_out <= 1'b1;
  endtask
  // Short low pulse
  task automatic glitch(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    line_out <= 1'b1;
  endtask
  // Decoder sampling mid bit
  initial forever
  begin : dec
    logic [8:0] b;
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clock_in);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CLKS) @(posedge clock_in);
      b[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clock_in);
    if (line_in !== 1'b1 || (^b) !== 1'b0) bad_cnt++;
    got_q.push_back(b[7:0]);
  end
endmodule // uartb_node

// file: tb/uart_buffered_tx_rx_errors_bench.sv
/*
  Bench: AXI4-Lite master tasks and one task per scenario.
  Assumes the remote node model on the serial pins.
*/
`timescale 1ns/1ps
module uart_buffered_tx_rx_errors_bench;
  import uartb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, tx_i, rx_i, er_i;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0;
  int tests_run = 0;
  int n_tx = 0;
  int n_rx = 0;
  int n_er = 0;
  initial forever #2.5 clk = ~clk;
  // Interrupt pulse counters
  always @(posedge clk)
  begin
    if (tx_i === 1'b1) n_tx++;
    if (rx_i === 1'b1) n_rx++;
    if (er_i === 1'b1) n_er++;
  end
  uartb_top uartb_top_inst (.clock_in(clk), .rst_in(rst), .axi_awaddr_in(awaddr),
    .axi_awvalid_in(awvalid), .axi_awready_out(awready), .axi_wdata_in(wdata),
    .axi_wstrb_in(4'h1), .axi_wvalid_in(wvalid), .axi_wready_out(wready),
    .axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
    .axi_araddr_in(araddr), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
    .axi_rready_in(rready), .serial_in_pin_in(rxd), .serial_out_pin_out(txd),
    .tx_done_irq_out(tx_i), .rx_done_irq_out(rx_i), .rx_error_irq_out(er_i));
  uartb_node uartb_node_inst (.clock_in(clk), .line_in(txd), .line_out(rxd));
  // ------------------------------------------------------------
  // Report and bus tasks
  // ------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task hang;
    chk("timeout", 32'h0, 32'h1);
    results();
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 300) hang();
    end
    while (s !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; !(aw && w); n++)
    begin
      @(posedge clk);
      if (n > 300) hang();
      aw = aw || awready === 1'b1;
      w = w || wready === 1'b1;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    wait_hi(bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(UARTB_RESP_OKAY));
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = UARTB_RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    wait_hi(rvalid);
    rready <= 1'b0;
    chk(nm, rdata, e);
    chk(nm, 32'(rresp), 32'(er));
  endtask
  task automatic rx_frame(input logic [7:0] d, input logic p, input logic s, input int r,
    input int e);
    uartb_node_inst.send(d, p, s);
    repeat (20) @(posedge clk);
    chk("rx_done count", n_rx, r);
    chk("rx_error count", n_er, e);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_tx;
    rd("mode", UARTB_ADDR_MODE, 32'h0);
    rd("div", UARTB_ADDR_DIV, 32'hff);
    rd("rxbuf", UARTB_ADDR_RXBUF, 32'hff);
    rd("unmapped", 8'h18, 32'h0, UARTB_RESP_SLVERR);
    wr(UARTB_ADDR_MODE, 32'hee);
    wr(UARTB_ADDR_DIV, 32'h08);
    rd("txst", UARTB_ADDR_TXST, 32'h0);
    wr(UARTB_ADDR_TXBUF, 32'ha5);
    rd("txst", UARTB_ADDR_TXST, 32'h1);
    wr(UARTB_ADDR_TXBUF, 32'h3c);
    rd("txst", UARTB_ADDR_TXST, 32'h3);
    for (int n = 0; uartb_node_inst.got_q.size() < 2; n++)
    begin
      @(posedge clk);
      if (n > 900) hang();
    end
    repeat (20) @(posedge clk);
    chk("byte0", 32'(uartb_node_inst.got_q[0]), 32'ha5);
    chk("byte1", 32'(uartb_node_inst.got_q[1]), 32'h3c);
    chk("frame faults", uartb_node_inst.bad_cnt, 0);
    chk("tx_done count", n_tx, 2);
    chk("txd idle", 32'(txd), 32'h1);
    rd("txst", UARTB_ADDR_TXST, 32'h0);
    $display("done t_tx");
  endtask
  task t_rx;
    wr(UARTB_ADDR_MODE, 32'hce);
    rx_frame(8'h5a, 1'b0, 1'b0, 0, 0);
    wr(UARTB_ADDR_MODE, 32'hee);
    rx_frame(8'h5a, 1'b0, 1'b0, 1, 0);
    rd("err", UARTB_ADDR_ERRST, 32'h0);
    rd("rxbuf", UARTB_ADDR_RXBUF, 32'h5a);
    rx_frame(8'h33, 1'b1, 1'b0, 1, 1);
    rd("err parity", UARTB_ADDR_ERRST, 32'h2);
    rd("err cleared", UARTB_ADDR_ERRST, 32'h0);
    rd("rxbuf", UARTB_ADDR_RXBUF, 32'h33);
    $display("done t_rx");
  endtask
  task t_ovr;
    wr(UARTB_ADDR_MODE, 32'hfe);
    rx_frame(8'h11, 1'b0, 1'b0, 2, 1);
    rx_frame(8'h22, 1'b0, 1'b1, 2, 2);
    rd("err ovr frm", UARTB_ADDR_ERRST, 32'h5);
    rd("rxbuf kept", UARTB_ADDR_RXBUF, 32'h11);
    wr(UARTB_ADDR_MODE, 32'hef);
    rx_frame(8'h44, 1'b1, 1'b0, 3, 2);
    rd("err merge", UARTB_ADDR_ERRST, 32'h2);
    rd("rxbuf", UARTB_ADDR_RXBUF, 32'h44);
    uartb_node_inst.glitch(5);
    repeat (200) @(posedge clk);
    chk("glitch rx_done", n_rx, 3);
    rd("err glitch", UARTB_ADDR_ERRST, 32'h0);
    wr(UARTB_ADDR_MODE, 32'hec);
    rx_frame(8'h81, 1'b1, 1'b0, 4, 2);
    rd("err odd", UARTB_ADDR_ERRST, 32'h0);
    rd("rxbuf odd", UARTB_ADDR_RXBUF, 32'h81);
    $display("done t_ovr");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_tx();
    t_rx();
    t_ovr();
    results();
  end
endmodule // uart_buffered_tx_rx_errors_bench
